// ===== bisync_channel_framer.sv
// Operation
// - between frames transmitter idles with SYN characters or steady mark
// - mark idle sends a programmed count of AA or 00 leading pads
// - frame starts when FIFO has data: pads, SYN pair, then host bytes
// - transmitter classifies frame; SYNs in the header, in normal text and in DLE-SYN pairs are sent but not checked
// - abort command during a frame, before its last byte is taken, sends EOT, one trailing pad, then idles
// - frame ending EOT/ENQ gets only a pad; else BCC then pad
// - receiver hunts for SYN SYN; next non-SYN byte starts the frame
// - receiver classifies frame and checks only bytes that belong in BCC
// - frame end with BCC verifies it and posts end-of-frame status
// - frame ending ENQ skips the check and posts abort
// - extra termination character ends the frame at once, no BCC
// - channel init loads extra termination register with DLE (10 hex)
// - termination character after DLE does not end the frame
// - SYN SYN STX ENQ reports CRC error and abort, passes STX ENQ
// - after ITB or DLE-ITB the check starts at first byte, STX or SOH included
// - otherwise the check starts after STX, SOH, DLE-STX or DLE-SOH
// - non-transparent end: ETX/ETB/ITB checked, two BCC bytes follow with CRC, one with LRC
// - transparent end: DLE not checked, terminator checked, two BCC follow with CRC, one with LRC
// - transparent receive skips first DLE of pairs; DLE-SYN skips both
// - transparent receive checks per transparency and strips escape DLEs
// - check type is top bit of code set option register: 1 selects LRC
// - CRC-16 uses x16+x15+x2+1 starting from all zeros
// - LRC is per-bit parity over checked characters, parity bits excluded
module bisync_channel_framer
	import bisync_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// transmit data from host fifo
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_eof,
	output logic tx_ready,
	// receive data to host
	output logic rx_valid,
	output logic [7:0] rx_data,
	// line side, one character per serial character clock
	input wire logic char_clk_pin,
	input wire logic [7:0] line_rx_char,
	output logic [7:0] line_tx_char
);
	import bisync_pkg::*;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_LPAD = 3'h1, TX_SYN1 = 3'h2, TX_SYN2 = 3'h3,
		TX_DATA = 3'h4, TX_BCC1 = 3'h5, TX_BCC2 = 3'h6, TX_TPAD = 3'h7
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_HUNT = 3'h0, RX_HUNT2 = 3'h1, RX_FRAME = 3'h2, RX_BCC1 = 3'h3, RX_BCC2 = 3'h4
	} rx_state_t;

	logic [7:0] char_fmt_reg;
	logic [7:0] code_chk_reg;
	logic [7:0] extra_frame_term_char_reg;
	logic [7:0] tx_cfg_reg;
	logic [3:0] rx_interrupt_status;
	logic abort_pend_reg;
	logic teoi_pend_reg;
	logic [2:0] tick_sync;
	logic tick_lvl_reg;
	logic tick_lvl_next;
	logic tick;
	logic [7:0] rx_s1;
	logic [7:0] rx_s2;
	logic [7:0] rx_s3;
	tx_state_t tx_state;
	rx_state_t rx_state;
	phase_t tx_ph;
	phase_t rx_ph;
	logic [15:0] tx_bcc;
	logic [15:0] rx_bcc;
	logic tx_itb_reg;
	logic rx_itb_reg;
	logic [3:0] pad_cnt_reg;
	logic [3:0] rx_evt_reg;
	logic ebc;
	logic lrc;
	logic [7:0] len_mask;
	logic wr_stcmd;
	logic init_cmd;
	logic abort_cmd;
	logic teoi_cmd;
	logic [7:0] rb;
	cls_t tx_cls;
	cls_t rx_cls;
	logic [15:0] rx_chk;
	logic xterm_hit;

	assign ebc = code_chk_reg[CODE_EBCDIC_BIT];
	assign lrc = code_chk_reg[CHK_LRC_BIT];
	assign wr_stcmd = reg_wr && reg_addr == OFS_STCMD;
	assign init_cmd = wr_stcmd && reg_wdata[STC_INIT_BIT];
	assign abort_cmd = wr_stcmd && reg_wdata[STC_ABORT_BIT];
	assign teoi_cmd = reg_wr && reg_addr == OFS_TEOI && reg_wdata[TEOI_EOF_BIT];
	// parity never reaches this byte, so masking to the character length is all LRC needs
	assign len_mask = 8'hFF >> (2'd3 - char_fmt_reg[LEN_LSB +: 2]);

	// one step of the block check over a byte
	function automatic logic [15:0] bcc_step(input logic [15:0] b, input logic [7:0] d,
			input logic use_lrc, input logic [7:0] m);
		logic [15:0] c;
		logic fb;
		c = b;
		fb = 1'b0;
		if (use_lrc) begin
			c = {8'h00, b[7:0] ^ (d & m)};
		end else begin
			for (int i = 0; i < 8; i++) begin
				fb = c[0] ^ d[i];
				c = c >> 1;
				if (fb) begin
					c = c ^ CRC_POLY_REFL;
				end
			end
		end
		return c;
	endfunction

	// frame-type tracking shared by both directions
	function automatic cls_t classify(input logic [7:0] d, input phase_t ph,
			input logic itb, input logic e);
		cls_t r;
		logic is_term;
		logic is_end0;
		r = '0;
		r.next = ph;
		is_term = d == ctl_code(C_ETX, e) || d == ctl_code(C_ETB, e)
			|| d == ctl_code(C_ITB, e);
		is_end0 = d == ctl_code(C_ENQ, e) || d == ctl_code(C_EOT, e);
		r.is_itb = d == ctl_code(C_ITB, e);
		unique case (ph)
			PH_HDR: begin
				if (d == ctl_code(C_DLE, e)) begin
					r.next = PH_HDR_DLE;
					r.count = itb;
				end else if (d == ctl_code(C_STX, e) || d == ctl_code(C_SOH, e)) begin
					r.next = PH_TEXT;
					r.count = itb;
				end else if (is_end0) begin
					r.end_nobcc = 1'b1;
				end else if (d != ctl_code(C_SYN, e)) begin
					r.next = PH_TEXT;
					r.count = 1'b1;
				end
			end
			PH_HDR_DLE: begin
				r.count = 1'b1;
				r.next = PH_TEXT;
				if (d == ctl_code(C_STX, e) || d == ctl_code(C_SOH, e)) begin
					r.next = PH_XP;
					r.count = itb;
				end
			end
			PH_TEXT: begin
				if (d == ctl_code(C_DLE, e)) begin
					r.next = PH_ESC;
				end else if (is_end0) begin
					r.end_nobcc = 1'b1;
				end else if (d != ctl_code(C_SYN, e)) begin
					r.count = 1'b1;
					r.end_bcc = is_term;
				end
			end
			PH_XP: begin
				r.count = d != ctl_code(C_DLE, e);
				r.strip = d == ctl_code(C_DLE, e);
				if (d == ctl_code(C_DLE, e)) begin
					r.next = PH_ESC;
				end
			end
			PH_ESC: begin
				r.next = PH_XP;
				if (d == ctl_code(C_SYN, e)) begin
					r.strip = 1'b1;
				end else if (is_end0) begin
					r.end_nobcc = 1'b1;
				end else begin
					r.count = 1'b1;
					r.end_bcc = is_term;
				end
			end
			default: begin
				r.next = PH_HDR;
			end
		endcase
		return r;
	endfunction

	// character clock pin: three stages, a level counts once stages two and three agree
	always_comb begin
		tick_lvl_next = tick_lvl_reg;
		if (tick_sync[2] == tick_sync[1]) begin
			tick_lvl_next = tick_sync[2];
		end
	end
	assign tick = tick_lvl_next && !tick_lvl_reg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_sync <= 3'h0;
			tick_lvl_reg <= 1'b0;
			rx_s1 <= 8'h00;
			rx_s2 <= 8'h00;
			rx_s3 <= 8'h00;
		end else begin
			tick_sync <= {tick_sync[1:0], char_clk_pin};
			tick_lvl_reg <= tick_lvl_next;
			rx_s1 <= line_rx_char;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end

	// register writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			char_fmt_reg <= RST_CHAR_FMT;
			code_chk_reg <= RST_CODE_CHK;
			extra_frame_term_char_reg <= RST_XTERM;
			tx_cfg_reg <= RST_TX_CFG;
		end else if (init_cmd) begin
			extra_frame_term_char_reg <= DLE_CODE;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_CHAR_FMT: char_fmt_reg <= reg_wdata;
				OFS_CODE_CHK: code_chk_reg <= reg_wdata;
				OFS_XTERM: extra_frame_term_char_reg <= reg_wdata;
				OFS_TX_CFG: tx_cfg_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// sticky receive status, write one to clear; a new event wins over the clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_interrupt_status <= 4'h0;
		end else if (reg_wr && reg_addr == OFS_RX_STAT) begin
			rx_interrupt_status <= (rx_interrupt_status & ~reg_wdata[3:0]) | rx_evt_reg;
		end else begin
			rx_interrupt_status <= rx_interrupt_status | rx_evt_reg;
		end
	end

	// register reads, data one cycle after the strobe
	always_comb begin
		unique case (reg_addr)
			OFS_CHAR_FMT: rb = char_fmt_reg;
			OFS_CODE_CHK: rb = code_chk_reg;
			OFS_XTERM: rb = extra_frame_term_char_reg;
			OFS_STCMD: rb = {7'h00, abort_pend_reg};
			OFS_TX_CFG: rb = tx_cfg_reg;
			OFS_TEOI: rb = {7'h00, teoi_pend_reg};
			OFS_RX_STAT: rb = {4'h0, rx_interrupt_status};
			OFS_STATE: rb = {tx_state, rx_state, tx_itb_reg, rx_itb_reg};
			default: rb = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rb : 8'h00;
		end
	end

	// pending commands; a command in the cycle it is consumed stays pending
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			abort_pend_reg <= 1'b0;
			teoi_pend_reg <= 1'b0;
		end else begin
			if (abort_cmd) begin
				abort_pend_reg <= 1'b1;
			end else if (tick && (tx_state == TX_DATA || tx_state == TX_IDLE)) begin
				abort_pend_reg <= 1'b0;
			end
			if (teoi_cmd) begin
				teoi_pend_reg <= 1'b1;
			end else if (tx_ready && tx_valid) begin
				teoi_pend_reg <= 1'b0;
			end
		end
	end

	// transmitter
	// an init in the same cycle would swallow the byte, so it is refused then
	assign tx_ready = tick && tx_state == TX_DATA && !abort_pend_reg && !init_cmd;
	assign tx_cls = classify(tx_data, tx_ph, tx_itb_reg, ebc);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_state <= TX_IDLE;
			line_tx_char <= MARK_FILL;
			tx_ph <= PH_HDR;
			tx_bcc <= BCC_INIT;
			tx_itb_reg <= 1'b0;
			pad_cnt_reg <= 4'h0;
		end else if (init_cmd) begin
			tx_itb_reg <= 1'b0;
		end else if (tick) begin
			unique case (tx_state)
				TX_IDLE: begin
					line_tx_char <= tx_cfg_reg[TXC_MARK_BIT] ? MARK_FILL
						: ctl_code(C_SYN, ebc);
					pad_cnt_reg <= tx_cfg_reg[TXC_PADCNT_LSB +: 4];
					if (tx_valid && !abort_pend_reg) begin
						tx_state <= TX_SYN1;
						if (tx_cfg_reg[TXC_MARK_BIT] && tx_cfg_reg[TXC_PADCNT_LSB +: 4] != 4'h0) begin
							tx_state <= TX_LPAD;
						end
					end
				end
				TX_LPAD: begin
					line_tx_char <= tx_cfg_reg[TXC_PAD00_BIT] ? PAD_00 : PAD_AA;
					pad_cnt_reg <= pad_cnt_reg - 4'h1;
					if (pad_cnt_reg == 4'h1) begin
						tx_state <= TX_SYN1;
					end
				end
				TX_SYN1: begin
					line_tx_char <= ctl_code(C_SYN, ebc);
					tx_state <= TX_SYN2;
				end
				TX_SYN2: begin
					line_tx_char <= ctl_code(C_SYN, ebc);
					tx_state <= TX_DATA;
					tx_ph <= PH_HDR;
					tx_bcc <= BCC_INIT;
				end
				TX_DATA: begin
					if (abort_pend_reg) begin
						line_tx_char <= ctl_code(C_EOT, ebc);
						tx_itb_reg <= 1'b0;
						tx_state <= TX_TPAD;
					end else if (tx_valid) begin
						// data goes out as given: escape DLEs are the host's job
						line_tx_char <= tx_data;
						tx_ph <= tx_cls.next;
						if (tx_cls.count) begin
							tx_bcc <= bcc_step(tx_bcc, tx_data, lrc, len_mask);
						end
						if (tx_eof || teoi_pend_reg) begin
							tx_itb_reg <= tx_cls.end_bcc && tx_cls.is_itb;
							tx_state <= tx_cls.end_nobcc ? TX_TPAD : TX_BCC1;
						end
					end else begin
						// underrun fill, kept out of the check
						line_tx_char <= ctl_code(C_SYN, ebc);
					end
				end
				TX_BCC1: begin
					line_tx_char <= tx_bcc[7:0];
					tx_state <= lrc ? TX_TPAD : TX_BCC2;
				end
				TX_BCC2: begin
					line_tx_char <= tx_bcc[15:8];
					tx_state <= TX_TPAD;
				end
				TX_TPAD: begin
					line_tx_char <= TRAIL_PAD;
					tx_state <= TX_IDLE;
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// receiver
	assign rx_cls = classify(rx_s3, rx_ph, rx_itb_reg, ebc);
	assign rx_chk = bcc_step(rx_bcc, rx_s3, lrc, len_mask);
	// the terminator is inert while it equals DLE, else every DLE would end the frame
	assign xterm_hit = extra_frame_term_char_reg != DLE_CODE
		&& rx_s3 == extra_frame_term_char_reg
		&& rx_ph != PH_ESC && rx_ph != PH_HDR_DLE;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_state <= RX_HUNT;
			rx_ph <= PH_HDR;
			rx_bcc <= BCC_INIT;
			rx_itb_reg <= 1'b0;
			rx_evt_reg <= 4'h0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else if (init_cmd) begin
			rx_state <= RX_HUNT;
			rx_itb_reg <= 1'b0;
			rx_evt_reg <= 4'h0;
			rx_valid <= 1'b0;
		end else begin
			rx_evt_reg <= 4'h0;
			rx_valid <= 1'b0;
			if (tick) begin
				unique case (rx_state)
					RX_HUNT: begin
						if (rx_s3 == ctl_code(C_SYN, ebc)) begin
							rx_state <= RX_HUNT2;
						end
					end
					RX_HUNT2: begin
						rx_state <= RX_HUNT;
						if (rx_s3 == ctl_code(C_SYN, ebc)) begin
							rx_state <= RX_FRAME;
							rx_ph <= PH_HDR;
							rx_bcc <= BCC_INIT;
						end
					end
					RX_FRAME: begin
						if (!rx_cls.strip
								&& !(rx_ph == PH_HDR && rx_s3 == ctl_code(C_SYN, ebc))) begin
							rx_data <= rx_s3;
							rx_valid <= 1'b1;
						end
						if (xterm_hit) begin
							rx_evt_reg[RIS_EOF_BIT] <= 1'b1;
							rx_evt_reg[RIS_XTERM_BIT] <= 1'b1;
							rx_itb_reg <= 1'b0;
							rx_state <= RX_HUNT;
						end else begin
							rx_ph <= rx_cls.next;
							if (rx_cls.count) begin
								rx_bcc <= rx_chk;
							end
							if (rx_cls.end_nobcc) begin
								rx_itb_reg <= 1'b0;
								rx_state <= RX_HUNT;
								if (rx_s3 == ctl_code(C_ENQ, ebc)) begin
									rx_evt_reg[RIS_ABORT_BIT] <= 1'b1;
									rx_evt_reg[RIS_CRC_BIT] <= rx_ph != PH_HDR;
								end else begin
									rx_evt_reg[RIS_EOF_BIT] <= 1'b1;
								end
							end else if (rx_cls.end_bcc) begin
								rx_itb_reg <= rx_cls.is_itb;
								rx_state <= RX_BCC1;
							end
						end
					end
					RX_BCC1: begin
						// stepping the received check through the sum leaves zero when good
						rx_bcc <= rx_chk;
						rx_state <= RX_BCC2;
						if (lrc) begin
							rx_evt_reg[RIS_EOF_BIT] <= 1'b1;
							rx_evt_reg[RIS_CRC_BIT] <= rx_chk != 16'h0000;
							rx_state <= rx_itb_reg ? RX_FRAME : RX_HUNT;
							rx_ph <= PH_HDR;
							rx_bcc <= BCC_INIT;
						end
					end
					RX_BCC2: begin
						rx_evt_reg[RIS_EOF_BIT] <= 1'b1;
						rx_evt_reg[RIS_CRC_BIT] <= rx_chk != 16'h0000;
						rx_state <= rx_itb_reg ? RX_FRAME : RX_HUNT;
						rx_ph <= PH_HDR;
						rx_bcc <= BCC_INIT;
					end
					default: rx_state <= RX_HUNT;
				endcase
			end
		end
	end

endmodule

// ===== bisync_pkg.sv
package bisync_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CHAR_FMT = 8'h00;
	localparam logic [7:0] OFS_CODE_CHK = 8'h04;
	localparam logic [7:0] OFS_XTERM = 8'h08;
	localparam logic [7:0] OFS_STCMD = 8'h0C;
	localparam logic [7:0] OFS_TX_CFG = 8'h10;
	localparam logic [7:0] OFS_TEOI = 8'h14;
	localparam logic [7:0] OFS_RX_STAT = 8'h18;
	localparam logic [7:0] OFS_STATE = 8'h1C;

	// reset values
	localparam logic [7:0] RST_CHAR_FMT = 8'h03;
	localparam logic [7:0] RST_CODE_CHK = 8'h00;
	localparam logic [7:0] RST_XTERM = 8'h10;
	localparam logic [7:0] RST_TX_CFG = 8'h00;

	// field positions
	localparam int LEN_LSB = 0;
	localparam int CHK_LRC_BIT = 7;
	localparam int CODE_EBCDIC_BIT = 0;
	localparam int STC_ABORT_BIT = 0;
	localparam int STC_INIT_BIT = 1;
	localparam int TXC_MARK_BIT = 0;
	localparam int TXC_PAD00_BIT = 1;
	localparam int TXC_PADCNT_LSB = 4;
	localparam int TEOI_EOF_BIT = 0;
	localparam int RIS_EOF_BIT = 0;
	localparam int RIS_CRC_BIT = 1;
	localparam int RIS_ABORT_BIT = 2;
	localparam int RIS_XTERM_BIT = 3;

	// fill and check constants
	localparam logic [7:0] PAD_AA = 8'hAA;
	localparam logic [7:0] PAD_00 = 8'h00;
	localparam logic [7:0] TRAIL_PAD = 8'hFF;
	localparam logic [7:0] MARK_FILL = 8'hFF;
	localparam logic [7:0] DLE_CODE = 8'h10;
	localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
	localparam logic [15:0] BCC_INIT = 16'h0000;

	typedef enum logic [3:0] {
		C_SYN = 4'h0, C_DLE = 4'h1, C_STX = 4'h2, C_SOH = 4'h3, C_ETX = 4'h4,
		C_ETB = 4'h5, C_ITB = 4'h6, C_ENQ = 4'h7, C_EOT = 4'h8
	} ctl_t;

	typedef enum logic [2:0] {
		PH_HDR = 3'h0, PH_HDR_DLE = 3'h1, PH_TEXT = 3'h2, PH_XP = 3'h3, PH_ESC = 3'h4
	} phase_t;

	typedef struct packed {
		logic count;
		logic strip;
		logic end_bcc;
		logic end_nobcc;
		logic is_itb;
		phase_t next;
	} cls_t;

	function automatic logic [7:0] ctl_code(input ctl_t c, input logic ebc);
		unique case (c)
			C_SYN: ctl_code = ebc ? 8'h32 : 8'h16;
			C_DLE: ctl_code = DLE_CODE;
			C_STX: ctl_code = 8'h02;
			C_SOH: ctl_code = 8'h01;
			C_ETX: ctl_code = 8'h03;
			C_ETB: ctl_code = ebc ? 8'h26 : 8'h17;
			C_ITB: ctl_code = 8'h1F;
			C_ENQ: ctl_code = ebc ? 8'h2D : 8'h05;
			C_EOT: ctl_code = ebc ? 8'h37 : 8'h04;
			default: ctl_code = 8'h00;
		endcase
	endfunction

endpackage

// ===== bisync_channel_framer_assertions.sv
module bisync_channel_framer_assertions (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// watched ports
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic char_clk_pin,
	input wire logic [7:0] line_tx_char
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// a byte is taken only in a tick cycle
	sequence s_take;
		tx_ready && tx_valid;
	endsequence

	// a tick comes several cycles into the high phase of the pin
	sequence s_pin_high;
		$past(char_clk_pin, 2);
	endsequence

	a_rdata_slot_only: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data seen outside its slot");
	a_take_sent: assert property (s_take |=> line_tx_char == $past(tx_data))
		else $error("taken byte not on the line next cycle");
	a_take_at_tick: assert property (tx_ready |-> s_pin_high)
		else $error("byte taken away from a character tick");
	a_take_once: assert property (tx_ready |=> (!tx_ready) [*4])
		else $error("two bytes taken within one character");
	a_line_holds: assert property ($changed(line_tx_char) |=> $stable(line_tx_char) [*4])
		else $error("line character changed within one character");
	a_rx_once: assert property (rx_valid |=> (!rx_valid) [*4])
		else $error("two received bytes within one character");
	a_rx_at_tick: assert property (rx_valid |-> $past(char_clk_pin, 3))
		else $error("received byte away from a character tick");
	a_rx_data_new: assert property ($changed(rx_data) |-> rx_valid)
		else $error("receive data changed without a valid pulse");
endmodule

bind bisync_channel_framer bisync_channel_framer_assertions i_chk (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.tx_valid(tx_valid),
	.tx_data(tx_data),
	.tx_ready(tx_ready),
	.rx_valid(rx_valid),
	.rx_data(rx_data),
	.char_clk_pin(char_clk_pin),
	.line_tx_char(line_tx_char)
);

// ===== bisync_remote_station.sv
module bisync_remote_station (
	// clock
	input wire logic ref_clk,
	// line side
	output logic char_clk_pin,
	output logic [7:0] line_rx_char,
	input wire logic [7:0] line_tx_char
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	int ph;

	// sync line clock runs free; 8 cycles high, 8 low, so the tick filter always settles
	// new character goes out at the fall, well clear of the rise where it is taken
	// an empty queue sends mark fill, as an idle line does
	initial begin
		char_clk_pin = 1'b0;
		line_rx_char = 8'hFF;
		ph = 0;
		forever begin
			@(posedge ref_clk);
			ph <= (ph == 15) ? 0 : ph + 1;
			if (ph == 7) begin
				char_clk_pin <= 1'b1;
			end
			if (ph == 15) begin
				char_clk_pin <= 1'b0;
				txq.push_back(line_tx_char);
				line_rx_char <= (rxq.size() > 0) ? rxq.pop_front() : 8'hFF;
			end
		end
	end
endmodule

// ===== bisync_channel_framer_tb_top.sv
module bisync_channel_framer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bisync_pkg::*;
	logic ref_clk, nrst, reg_wr, reg_rd, tx_valid, tx_eof, tx_ready, rx_valid, char_clk_pin;
	logic [7:0] reg_addr, reg_wdata, tx_data, reg_rdata, rx_data, line_rx_char, line_tx_char;
	logic [7:0] rxd[$];
	logic [7:0] rv;
	logic [15:0] c, c2;
	int errors, checks_done;

	bisync_channel_framer i_bisync_channel_framer (.ref_clk(ref_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_eof(tx_eof),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.char_clk_pin(char_clk_pin), .line_rx_char(line_rx_char), .line_tx_char(line_tx_char));

	bisync_remote_station i_remote (.ref_clk(ref_clk), .char_clk_pin(char_clk_pin),
		.line_rx_char(line_rx_char), .line_tx_char(line_tx_char));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1) begin
			rxd.push_back(rx_data);
		end
	end

	task automatic finish_test;
		if (errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			errors++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		rv = reg_rdata;
		chk({8'h00, rv}, {8'h00, e});
	endtask

	task automatic wait_ticks(input int n);
		repeat (n * 16) @(posedge ref_clk);
	endtask

	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] r;
		r = 16'h0000;
		foreach (b[i]) begin
			r = r ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		end
		return r;
	endfunction

	// line capture restarts here so a match cannot come from an earlier frame
	task automatic send(input logic [7:0] b[$], input logic eof);
		int n;
		i_remote.txq.delete();
		foreach (b[i]) begin
			tx_valid <= 1'b1;
			tx_data <= b[i];
			tx_eof <= eof && (i == b.size() - 1);
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (tx_ready !== 1'b1 && n < 400);
			bound(n, 400);
		end
		tx_valid <= 1'b0;
		tx_eof <= 1'b0;
	endtask

	task automatic expect_tx(input logic [7:0] e[$]);
		int hit;
		hit = 0;
		for (int i = 0; i + e.size() <= i_remote.txq.size(); i++) begin
			int k;
			k = 0;
			while (k < e.size() && i_remote.txq[i + k] === e[k]) k++;
			if (k == e.size()) hit = 1;
		end
		chk(16'(hit), 16'h0001);
	endtask

	task automatic rx_frame(input logic [7:0] b[$], input logic [7:0] st, input logic [7:0] d[$]);
		int n;
		wr(OFS_RX_STAT, 8'hFF);
		rxd.delete();
		foreach (b[i]) i_remote.rxq.push_back(b[i]);
		n = 0;
		while (i_remote.rxq.size() > 0 && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		bound(n, 4000);
		wait_ticks(4);
		rchk(OFS_RX_STAT, st);
		chk(16'(rxd.size()), 16'(d.size()));
		foreach (d[i]) if (i < rxd.size()) chk({8'h00, rxd[i]}, {8'h00, d[i]});
	endtask

	initial begin
		nrst = 1'b0;
		{reg_wr, reg_rd, tx_valid, tx_eof} = 4'h0;
		{reg_addr, reg_wdata, tx_data} = 24'h000000;
		errors = 0;
		checks_done = 0;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		rchk(OFS_CHAR_FMT, 8'h03);
		rchk(OFS_CODE_CHK, 8'h00);
		rchk(OFS_TX_CFG, 8'h00);
		rchk(OFS_XTERM, 8'h10);
		wr(8'h20, 8'h5A);
		rchk(8'h20, 8'h00);
		wr(OFS_XTERM, 8'h55);
		rchk(OFS_XTERM, 8'h55);
		wr(OFS_STCMD, 8'h02);
		rchk(OFS_XTERM, 8'h10);
		// syn idle, host-embedded syn stays out of the check
		send('{8'h02, 8'h41, 8'h16, 8'h42, 8'h03}, 1'b1);
		wait_ticks(8);
		c = crc_of('{8'h41, 8'h42, 8'h03});
		expect_tx('{8'h16, 8'h16, 8'h16, 8'h02, 8'h41, 8'h16, 8'h42, 8'h03, c[7:0], c[15:8],
			8'hFF, 8'h16});
		send('{8'h10, 8'h02, 8'h41, 8'h10, 8'h03}, 1'b1);
		wait_ticks(8);
		c = crc_of('{8'h41, 8'h03});
		expect_tx('{8'h16, 8'h10, 8'h02, 8'h41, 8'h10, 8'h03, c[7:0], c[15:8], 8'hFF});
		wr(OFS_CODE_CHK, 8'h80);
		send('{8'h02, 8'h41, 8'h03}, 1'b1);
		wait_ticks(8);
		expect_tx('{8'h16, 8'h16, 8'h02, 8'h41, 8'h03, 8'h42, 8'hFF, 8'h16});
		wr(OFS_CODE_CHK, 8'h00);
		wr(OFS_TX_CFG, 8'h21);
		wait_ticks(3);
		send('{8'h02, 8'h05}, 1'b1);
		wait_ticks(8);
		expect_tx('{8'hFF, 8'hAA, 8'hAA, 8'h16, 8'h16, 8'h02, 8'h05, 8'hFF, 8'hFF});
		wr(OFS_TX_CFG, 8'h13);
		wait_ticks(3);
		send('{8'h02, 8'h41, 8'h03}, 1'b1);
		wait_ticks(8);
		expect_tx('{8'hFF, 8'h00, 8'h16, 8'h16, 8'h02, 8'h41, 8'h03, c[7:0], c[15:8],
			8'hFF, 8'hFF});
		// abort mid-frame while the host has nothing more to give
		wr(OFS_TX_CFG, 8'h00);
		wait_ticks(3);
		send('{8'h02, 8'h41}, 1'b0);
		wait_ticks(2);
		wr(OFS_STCMD, 8'h01);
		wait_ticks(6);
		expect_tx('{8'h16, 8'h16, 8'h02, 8'h41});
		expect_tx('{8'h04, 8'hFF, 8'h16});
		// ebcdic syn, frame end given by the end-of-interrupt register
		wr(OFS_CODE_CHK, 8'h01);
		send('{8'h02, 8'h41}, 1'b0);
		wait_ticks(2);
		expect_tx('{8'h32, 8'h32, 8'h02, 8'h41});
		wr(OFS_TEOI, 8'h01);
		rchk(OFS_TEOI, 8'h01);
		send('{8'h03}, 1'b0);
		wait_ticks(8);
		expect_tx('{8'h03, c[7:0], c[15:8], 8'hFF, 8'h32});
		wr(OFS_CODE_CHK, 8'h00);
		rx_frame('{8'h41, 8'h16, 8'h55, 8'h16, 8'h16, 8'h02, 8'h41, 8'h03, c[7:0], c[15:8]},
			8'h01, '{8'h02, 8'h41, 8'h03});
		rx_frame('{8'h16, 8'h16, 8'h02, 8'h41, 8'h03, c[7:0] ^ 8'h01, c[15:8]},
			8'h03, '{8'h02, 8'h41, 8'h03});
		rx_frame('{8'h16, 8'h16, 8'h02, 8'h05, 8'hFF, 8'hFF},
			8'h06, '{8'h02, 8'h05});
		c = crc_of('{8'h41, 8'h10, 8'h03});
		rx_frame('{8'h16, 8'h16, 8'h10, 8'h02, 8'h41, 8'h10, 8'h16, 8'h10, 8'h10, 8'h10, 8'h03,
			c[7:0], c[15:8]}, 8'h01, '{8'h10, 8'h02, 8'h41, 8'h10, 8'h03});
		// a frame closed by DLE-ITB restarts its check, which then takes in the next header's STX
		c = crc_of('{8'h41, 8'h1F});
		c2 = crc_of('{8'h02, 8'h42, 8'h03});
		rx_frame('{8'h16, 8'h16, 8'h10, 8'h02, 8'h41, 8'h10, 8'h1F, c[7:0], c[15:8], 8'h16, 8'h16,
			8'h02, 8'h42, 8'h03, c2[7:0], c2[15:8]}, 8'h01,
			'{8'h10, 8'h02, 8'h41, 8'h1F, 8'h02, 8'h42, 8'h03});
		wr(OFS_XTERM, 8'h55);
		rx_frame('{8'h16, 8'h16, 8'h02, 8'h41, 8'h55},
			8'h09, '{8'h02, 8'h41, 8'h55});
		rx_frame('{8'h16, 8'h16, 8'h02, 8'h10, 8'h55, 8'h42, 8'h55},
			8'h09, '{8'h02, 8'h10, 8'h55, 8'h42, 8'h55});
		finish_test();
	end
endmodule
